//--- lmpp_map.svh
`ifndef LMPP_MAP_SVH
`define LMPP_MAP_SVH
// register byte offsets
`define LMPP_CTRL_OFS      8'h00
`define LMPP_CFG_OFS       8'h04
`define LMPP_STAT_OFS      8'h08
`define LMPP_RES_LOW_OFS   8'h0C
`define LMPP_RES_HIGH_OFS  8'h10
`define LMPP_OFFSET_OFS    8'h14
// control word fields
`define LMPP_EN_BIT        0
`define LMPP_ONCE_BIT      1
`define LMPP_CS_LSB        2
`define LMPP_CN_LSB        16
// configuration word fields
`define LMPP_GAIN_BIT      0
`define LMPP_RECT_BIT      1
`define LMPP_FILT_BIT      2
`define LMPP_BAND_BIT      3
`define LMPP_BSRC_BIT      4
`define LMPP_NSRC_BIT      5
`define LMPP_OFTD_BIT      6
`define LMPP_SHIFT_LSB     8
`define LMPP_TH_LSB        12
// status word fields
`define LMPP_DONE_BIT      0
`define LMPP_OTH_BIT       1
// reset values: built-in coefficients selected
`define LMPP_CFG_RST       32'h0000_0030
// largest shift code that still halves
`define LMPP_SHIFT_MAX     4'hB
// one threshold step, an eighth of full scale
`define LMPP_TH_STEP       17'h0_1000
// done flag lifetime in continuous mode
`define LMPP_DONE_HOLD_NS  125000
`define LMPP_CLK_NS        10
`endif

//--- lmpp_pkg.sv
package lmpp_pkg;
   // measurement sequencer states
   typedef enum logic [1:0] {LMPP_IDLE, LMPP_RUN, LMPP_HOLD} lmpp_state_e;
   // software control word
   typedef struct packed {
      logic        meter_enable;
      logic        single_shot;
      logic [1:0]  channel_select;
      logic [10:0] integration_count;
   } lmpp_ctrl_s;
   // front-end settings for the sample path
   typedef struct packed {
      logic        gain_boost;
      logic        rectifier_on;
      logic        offset_default_select;
   } lmpp_front_s;
   // filter settings handed to the external filter
   typedef struct packed {
      logic        filter_enable;
      logic        band_or_notch;
      logic        band_coef_source;
      logic        notch_coef_source;
   } lmpp_filt_s;
endpackage : lmpp_pkg

//--- lmpp_sample_path.sv
`timescale 1ns/1ns
module lmpp_sample_path (
   // clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // incoming sample
   input  wire logic                      in_valid,
   input  wire logic signed [15:0]        in_sample,
   // settings
   input  wire lmpp_pkg::lmpp_front_s     front,
   input  wire logic signed [15:0]        offset_word,
   // processed sample
   output logic                           out_valid,
   output logic signed [21:0]             out_sample
);
   import lmpp_pkg::*;
   // compensation value, zero when the default is chosen
   wire logic signed [15:0] comp;
   // offset-corrected sample, one bit wider against overflow
   wire logic signed [16:0] corrected;
   // after the optional x16 gain
   wire logic signed [21:0] gained;
   // after the optional rectifier
   wire logic signed [21:0] rectified;

   assign comp = front.offset_default_select ? 16'sh0000 : offset_word;
   assign corrected = 17'(in_sample) - 17'(comp);
   // gain sits ahead of the rectifier so small signals keep resolution
   assign gained = front.gain_boost ? (22'(corrected) <<< 4)
                                    : 22'(corrected);
   // 22 bits leave room to negate the most negative gained value
   assign rectified = (front.rectifier_on && gained < 0) ? -gained
                                                        : gained;

   ////////////////////////////////////////////////////////////////////
   // register the processed sample with its strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid  <= 1'b0;
         out_sample <= 22'sh000000;
      end else begin
         out_valid  <= in_valid;
         out_sample <= rectified;
      end
   end

   a_rect_positive: assert property (@(posedge pclk) disable iff (!presetn)
      (in_valid && front.rectifier_on) |=> out_sample >= 0)
      else $error("rectified sample is negative");
endmodule : lmpp_sample_path

//--- lmpp_level_meter.sv
// Contract
// - shift code halves result, 1011+ gives 1/2048
// - latch compares magnitude, sets over-threshold flag
// - threshold code steps twelve and half percent
// - channel select picks the metered channel
// - integration count 0..7FF, 0.125 ms each
// - result read as low and high byte
// - filter enable inserts filter; bit picks band/notch
// - coefficient source bits; built-in after reset
// - enable starts accumulation, clearing it halts
// - done flag set when integration completes
// - gain boost multiplies sample by sixteen
// - rectifier folds negative samples positive
// - single shot runs once per enable
// - offset from memory word or zero
// - continuous done clears after 125 us
// - result bytes cleared while meter disabled
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "lmpp_map.svh"
module lmpp_level_meter #(
   // done flag lifetime in clock cycles, shortened in simulation
   parameter int unsigned DONE_HOLD_CYC = `LMPP_DONE_HOLD_NS / `LMPP_CLK_NS
) (
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   // codec channels at the 8 kHz sample rate
   input  wire logic [3:0][15:0]        ch_sample,
   input  wire logic                    sample_tick,
   // filter round trip
   output logic [15:0]                  sel_sample,
   output lmpp_pkg::lmpp_filt_s         filt_cfg,
   input  wire logic [15:0]             filt_sample,
   // status
   output logic                         measurement_done,
   output logic                         over_threshold_flag
);
   import lmpp_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // registers and state
   lmpp_ctrl_s         ctrl;           // control word
   lmpp_front_s        front;          // gain, rectifier, offset choice
   logic [3:0]         shift_code;     // shift factor code
   logic [2:0]         threshold_select; // threshold code
   logic [15:0]        offset_word;    // memory copy of the offset word
   logic [7:0]         result_low_reg; // result low byte
   logic [7:0]         result_high_reg; // result high byte
   lmpp_state_e        state;          // sequencer state
   logic [26:0]        acc;            // 27-bit integrator
   logic [10:0]        sample_cnt;     // samples summed so far
   logic [31:0]        done_timer;     // age of the done flag
   logic               sel_valid;      // strobe aligned with sel_sample
   logic [16:0]        magnitude_q;    // magnitude of the previous cycle
   logic [2:0]         threshold_select_q; // threshold code of the previous cycle

   ////////////////////////////////////////////////////////////////////
   // apb decode
   wire logic        setup_acc = psel && penable && !pready;
   wire logic        commit    = psel && penable && pready;
   wire logic        wr        = commit && pwrite && !pslverr;
   wire logic        hit_ctrl  = paddr == `LMPP_CTRL_OFS;
   wire logic        hit_cfg   = paddr == `LMPP_CFG_OFS;
   wire logic        hit_stat  = paddr == `LMPP_STAT_OFS;
   wire logic        hit_lo    = paddr == `LMPP_RES_LOW_OFS;
   wire logic        hit_hi    = paddr == `LMPP_RES_HIGH_OFS;
   wire logic        hit_ofs   = paddr == `LMPP_OFFSET_OFS;
   wire logic        mapped    = hit_ctrl | hit_cfg | hit_stat |
                                 hit_lo | hit_hi | hit_ofs;
   // result bytes are read only, a write to them is refused
   wire logic        bad       = !mapped || (pwrite && (hit_lo || hit_hi ||
                                 hit_stat));
   wire logic [31:0] ctrl_word =
      (32'(ctrl.meter_enable)     << `LMPP_EN_BIT) |
      (32'(ctrl.single_shot)      << `LMPP_ONCE_BIT) |
      (32'(ctrl.channel_select)   << `LMPP_CS_LSB) |
      (32'(ctrl.integration_count) << `LMPP_CN_LSB);
   wire logic [31:0] cfg_word =
      (32'(front.gain_boost)            << `LMPP_GAIN_BIT) |
      (32'(front.rectifier_on)          << `LMPP_RECT_BIT) |
      (32'(filt_cfg.filter_enable)      << `LMPP_FILT_BIT) |
      (32'(filt_cfg.band_or_notch)      << `LMPP_BAND_BIT) |
      (32'(filt_cfg.band_coef_source)   << `LMPP_BSRC_BIT) |
      (32'(filt_cfg.notch_coef_source)  << `LMPP_NSRC_BIT) |
      (32'(front.offset_default_select) << `LMPP_OFTD_BIT) |
      (32'(shift_code)                  << `LMPP_SHIFT_LSB) |
      (32'(threshold_select)            << `LMPP_TH_LSB);
   wire logic [31:0] stat_word =
      (32'(measurement_done)    << `LMPP_DONE_BIT) |
      (32'(over_threshold_flag) << `LMPP_OTH_BIT);
   wire logic [31:0] next_prdata =
      hit_ctrl ? ctrl_word :
      hit_cfg  ? cfg_word :
      hit_stat ? stat_word :
      hit_lo   ? {24'h000000, result_low_reg} :
      hit_hi   ? {24'h000000, result_high_reg} :
      hit_ofs  ? {16'h0000, offset_word} : 32'h0000_0000;

   // one wait state keeps prdata, pready and pslverr on flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_acc;
         pslverr <= setup_acc && bad;
         if (setup_acc && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // software-written registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl             <= '0;
         front            <= '0;
         // filter out, built-in coefficients for both characteristics
         filt_cfg         <= '{filter_enable:     1'b0,
                               band_or_notch:     1'b0,
                               band_coef_source:  1'b1,
                               notch_coef_source: 1'b1};
         shift_code       <= 4'h0;
         threshold_select <= 3'h0;
         offset_word      <= 16'h0000;
      end else if (wr && hit_ctrl) begin
         ctrl.meter_enable <= pwdata[`LMPP_EN_BIT];
         ctrl.single_shot  <= pwdata[`LMPP_ONCE_BIT];
         ctrl.channel_select <= pwdata[`LMPP_CS_LSB +: 2];
         ctrl.integration_count <= pwdata[`LMPP_CN_LSB +: 11];
      end else if (wr && hit_cfg) begin
         front.gain_boost   <= pwdata[`LMPP_GAIN_BIT];
         front.rectifier_on <= pwdata[`LMPP_RECT_BIT];
         front.offset_default_select <= pwdata[`LMPP_OFTD_BIT];
         filt_cfg.filter_enable     <= pwdata[`LMPP_FILT_BIT];
         filt_cfg.band_or_notch     <= pwdata[`LMPP_BAND_BIT];
         filt_cfg.band_coef_source  <= pwdata[`LMPP_BSRC_BIT];
         filt_cfg.notch_coef_source <= pwdata[`LMPP_NSRC_BIT];
         shift_code       <= pwdata[`LMPP_SHIFT_LSB +: 4];
         threshold_select <= pwdata[`LMPP_TH_LSB +: 3];
      end else if (wr && hit_ofs) begin
         offset_word <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // channel pick and filter bypass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_sample <= 16'h0000;
         sel_valid  <= 1'b0;
      end else begin
         sel_valid <= sample_tick;
         if (sample_tick) begin
            sel_sample <= ch_sample[ctrl.channel_select];
         end
      end
   end

   // the external filter must answer within the same cycle
   wire logic [15:0] path_in = filt_cfg.filter_enable ? filt_sample
                                                      : sel_sample;
   wire logic              proc_valid;
   wire logic signed [21:0] proc_sample;

   lmpp_sample_path u_path (
      .pclk        (pclk),
      .presetn     (presetn),
      .in_valid    (sel_valid),
      .in_sample   (path_in),
      .front       (front),
      .offset_word (offset_word),
      .out_valid   (proc_valid),
      .out_sample  (proc_sample)
   );

   ////////////////////////////////////////////////////////////////////
   // integrator bookkeeping
   // a zero count still integrates one sample period
   wire logic [10:0] target = (ctrl.integration_count == 11'h000) ? 11'h001
                             : ctrl.integration_count;
   wire logic [26:0] next_acc = acc + 27'(proc_sample);
   wire logic        running  = state == LMPP_RUN && ctrl.meter_enable;
   wire logic        finish   = running && proc_valid &&
                                (sample_cnt + 11'h001 >= target);
   // codes above the table all shift by eleven
   wire logic [3:0]  shift_eff = (shift_code > `LMPP_SHIFT_MAX)
                                 ? `LMPP_SHIFT_MAX : shift_code;
   wire logic signed [26:0] shifted = $signed(next_acc) >>> shift_eff;
   // saturate rather than wrap into the 16-bit result
   wire logic [15:0] next_result =
      (shifted > 27'sd32767)  ? 16'h7FFF :
      (shifted < -27'sd32768) ? 16'h8000 : shifted[15:0];
   wire logic [16:0] magnitude = next_result[15]
      ? 17'h0_0000 - {1'b1, next_result} : {1'b0, next_result};
   wire logic [16:0] limit = 17'(threshold_select) * `LMPP_TH_STEP;
   wire logic        over  = magnitude > limit;

   // sequencer: idle until enabled, single shot parks in hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LMPP_IDLE;
      end else if (!ctrl.meter_enable) begin
         state <= LMPP_IDLE;
      end else begin
         case (state)
            LMPP_IDLE: state <= LMPP_RUN;
            LMPP_RUN: begin
               if (finish && ctrl.single_shot) begin
                  state <= LMPP_HOLD;
               end
            end
            LMPP_HOLD: state <= LMPP_HOLD;
            default:   state <= LMPP_IDLE;
         endcase
      end
   end

   // accumulator and sample count, restarted at each period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc        <= 27'h0;
         sample_cnt <= 11'h000;
      end else if (!running || finish) begin
         acc        <= 27'h0;
         sample_cnt <= 11'h000;
      end else if (proc_valid) begin
         acc        <= next_acc;
         sample_cnt <= sample_cnt + 11'h001;
      end
   end

   // result bytes and over-threshold flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_low_reg      <= 8'h00;
         result_high_reg     <= 8'h00;
         over_threshold_flag <= 1'b0;
      end else if (!ctrl.meter_enable) begin
         result_low_reg      <= 8'h00;
         result_high_reg     <= 8'h00;
         over_threshold_flag <= 1'b0;
      end else if (finish) begin
         result_low_reg      <= next_result[7:0];
         result_high_reg     <= next_result[15:8];
         over_threshold_flag <= over;
      end
   end

   // done flag: a fresh completion wins over the timed clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         measurement_done <= 1'b0;
         done_timer       <= 32'h0;
      end else if (!ctrl.meter_enable) begin
         measurement_done <= 1'b0;
         done_timer       <= 32'h0;
      end else if (finish) begin
         measurement_done <= 1'b1;
         done_timer       <= 32'h0;
      end else if (measurement_done && !ctrl.single_shot) begin
         done_timer <= done_timer + 32'h1;
         if (done_timer + 32'h1 >= DONE_HOLD_CYC) begin
            measurement_done <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_finish;
      finish && ctrl.meter_enable;
   endsequence
   sequence s_latched;
      measurement_done && {result_high_reg, result_low_reg} == $past(next_result);
   endsequence

   a_done_on_end: assert property (@(posedge pclk) disable iff (!presetn)
      s_finish |=> s_latched)
      else $error("done flag or result missing after period end");
   a_over_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_finish |=> over_threshold_flag == (magnitude_q > 17'(threshold_select_q)
      * `LMPP_TH_STEP))
      else $error("over-threshold flag disagrees with result");
   a_off_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl.meter_enable |=> result_low_reg == 8'h00 && result_high_reg == 8'h00
      && !measurement_done)
      else $error("results not cleared while disabled");
   a_single_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (measurement_done && ctrl.single_shot && ctrl.meter_enable
       && $stable(ctrl.meter_enable)) |=> measurement_done)
      else $error("single-shot done flag dropped early");
   a_single_once: assert property (@(posedge pclk) disable iff (!presetn)
      (state == LMPP_HOLD && ctrl.meter_enable)
      |=> $stable({result_high_reg, result_low_reg}))
      else $error("single shot integrated twice");
   a_shift_clamp: assert property (@(posedge pclk) disable iff (!presetn)
      shift_code >= 4'hB |-> shifted == ($signed(next_acc) >>> 11))
      else $error("shift factor not clamped to 1/2048");
   a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
      running |-> sample_cnt < target)
      else $error("integration ran past programmed count");
   a_coef_reset: assert property (@(posedge pclk)
      $rose(presetn) |-> filt_cfg.band_coef_source
      && filt_cfg.notch_coef_source)
      else $error("built-in coefficients not selected after reset");
   a_start_run: assert property (@(posedge pclk) disable iff (!presetn)
      (state == LMPP_IDLE && ctrl.meter_enable) |=> state == LMPP_RUN)
      else $error("enable did not start the integrator");

   // helper copies sampled every cycle; the flag check reads those taken at the period end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         magnitude_q        <= 17'h0;
         threshold_select_q <= 3'h0;
      end else begin
         magnitude_q        <= magnitude;
         threshold_select_q <= threshold_select;
      end
   end
endmodule : lmpp_level_meter

//--- level_meter_post_processing_tb_top.sv
`timescale 1ns/1ns
`include "lmpp_map.svh"
module level_meter_post_processing_tb_top;
   import lmpp_pkg::*;
   localparam int DONE_HOLD = 20;      // shortened done lifetime
   // clock, reset and apb
   logic              pclk, presetn, psel, penable, pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata;
   logic              pready, pslverr;
   // sample side
   logic [3:0][15:0]  ch_sample;
   logic              sample_tick;
   logic [15:0]       sel_sample, filt_sample;
   lmpp_filt_s        filt_cfg;
   logic              measurement_done, over_threshold_flag;
   int                errors, checks_done;
   lmpp_level_meter #(.DONE_HOLD_CYC(DONE_HOLD)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ch_sample(ch_sample), .sample_tick(sample_tick),
      .sel_sample(sel_sample), .filt_cfg(filt_cfg),
      .filt_sample(filt_sample), .measurement_done(measurement_done),
      .over_threshold_flag(over_threshold_flag));
   ////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // tick every eight cycles, well above the three-cycle minimum spacing
   initial begin
      sample_tick = 1'b0;
      forever begin
         repeat (7) @(posedge pclk);
         sample_tick <= 1'b1;
         @(posedge pclk);
         sample_tick <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // compare and count; four-state so an unknown never matches
   task automatic cmp(input logic [31:0] got, input logic [31:0] ex,
                      input string m);
      checks_done++;
      if (got !== ex) begin
         errors++;
         $display("wrong value at %0t: %s got %h", $time, m, got);
      end
   endtask : cmp
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // look at the settled answer, then let the completing edge pass
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) cmp(1'b0, 1'b1, "apb no ready");
   endtask : apb
   // plain register write and read that expect no error
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      cmp(e, 1'b0, "write error");
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      cmp(e, 1'b0, "read error");
   endtask : rd
   // cfg word: bits[6:0] = oft, nsrc, bsrc, band, filt, rect, gain
   function automatic logic [31:0] mkcfg(input logic [6:0] b,
                                         input logic [3:0] k,
                                         input logic [2:0] th);
      return {17'h0, th, k, 1'b0, b};
   endfunction : mkcfg
   // single-shot run on one channel, others carry a decoy value
   task automatic meas(input logic [31:0] cfg, input logic [10:0] cnt,
                       input logic [1:0] ch, input logic [15:0] s,
                       input logic [15:0] ex, input logic eo);
      logic [31:0] lo, hi;
      int          n;
      wr(`LMPP_CTRL_OFS, {5'h0, cnt, 12'h0, ch, 2'b00});
      wr(`LMPP_CFG_OFS, cfg);
      for (n = 0; n < 4; n++) ch_sample[n] <= (n == ch) ? s : 16'h7FFF;
      wr(`LMPP_CTRL_OFS, {5'h0, cnt, 12'h0, ch, 2'b11});
      n = 0;
      while (measurement_done !== 1'b1 && n < 20000) begin
         @(negedge pclk);
         n++;
      end
      cmp(measurement_done, 1'b1, "done");
      cmp(sel_sample, s, "selected channel");
      rd(`LMPP_RES_LOW_OFS, lo);
      rd(`LMPP_RES_HIGH_OFS, hi);
      cmp({hi[7:0], lo[7:0]}, ex, "result");
      cmp(over_threshold_flag, eo, "over flag");
   endtask : meas
   ////////////////////////////////////////////////////////////////////////
   // reset values, refused accesses
   task automatic test_regs;
      logic [31:0] d;
      logic        e;
      cmp(filt_cfg, 4'b0011, "filter cfg reset");
      rd(`LMPP_CFG_OFS, d);
      cmp(d, `LMPP_CFG_RST, "cfg reset");
      rd(`LMPP_RES_LOW_OFS, d);
      cmp(d, 32'h0, "low byte reset");
      apb(1'b0, 8'h18, 32'h0, d, e);
      cmp(d, 32'h0, "unmapped read");
      cmp(e, 1'b1, "unmapped error");
      apb(1'b1, `LMPP_RES_HIGH_OFS, 32'hFF, d, e);
      cmp(e, 1'b1, "write to result");
      $display("test regs done");
   endtask : test_regs
   // shift codes incl. the saturating tail, count boundaries
   task automatic test_shift;
      int ks[5] = '{0, 2, 10, 11, 15};
      for (int i = 0; i < 5; i++)
         meas(mkcfg(7'h70, ks[i], 3'h0), 11'h4, i % 4, 16'h0400,
              16'h1000 >> ((ks[i] > 11) ? 11 : ks[i]), 1'b1);
      meas(mkcfg(7'h70, 0, 0), 11'h0, 2'h3, 16'h0400, 16'h0400, 1);
      meas(mkcfg(7'h70, 0, 0), 11'h7FF, 2'h1, 16'h1, 16'h07FF, 1);
      $display("test shift done");
   endtask : test_shift
   // limits at one step and seven steps, negative magnitude
   task automatic test_thresh;
      meas(mkcfg(7'h70, 0, 1), 11'h4, 2'h0, 16'h0400, 16'h1000, 0);
      meas(mkcfg(7'h70, 0, 1), 11'h4, 2'h1, 16'h0401, 16'h1004, 1);
      meas(mkcfg(7'h70, 0, 1), 11'h4, 2'h2, 16'hFBFF, 16'hEFFC, 1);
      meas(mkcfg(7'h70, 0, 7), 11'h4, 2'h3, 16'h0401, 16'h1004, 0);
      meas(mkcfg(7'h70, 0, 7), 11'h4, 2'h0, 16'h1C01, 16'h7004, 1);
      $display("test thresh done");
   endtask : test_thresh
   // gain, rectifier and offset ahead of the integrator
   task automatic test_front;
      meas(mkcfg(7'h71, 0, 0), 11'h4, 2'h2, 16'h0040, 16'h1000, 1);
      meas(mkcfg(7'h72, 0, 0), 11'h4, 2'h1, 16'hFFC0, 16'h0100, 1);
      meas(mkcfg(7'h70, 0, 0), 11'h4, 2'h1, 16'hFFC0, 16'hFF00, 1);
      wr(`LMPP_OFFSET_OFS, 32'h0100);
      meas(mkcfg(7'h30, 0, 0), 11'h4, 2'h0, 16'h0400, 16'h0C00, 1);
      meas(mkcfg(7'h70, 0, 0), 11'h4, 2'h0, 16'h0400, 16'h1000, 1);
      $display("test front done");
   endtask : test_front
   // filter inserted: result follows the filter return
   task automatic test_filter;
      filt_sample <= 16'h0200;
      meas(mkcfg(7'h7C, 0, 0), 11'h4, 2'h3, 16'h0400, 16'h0800, 1);
      cmp(filt_cfg, 4'b1111, "band filter cfg");
      meas(mkcfg(7'h64, 0, 0), 11'h4, 2'h2, 16'h0400, 16'h0800, 1);
      cmp(filt_cfg, 4'b1001, "notch filter cfg");
      $display("test filter done");
   endtask : test_filter
   // single shot holds done; disable clears it and the result
   task automatic test_single;
      logic [31:0] d;
      meas(mkcfg(7'h70, 0, 0), 11'h4, 2'h1, 16'h0400, 16'h1000, 1);
      repeat (60) @(posedge pclk);
      cmp(measurement_done, 1'b1, "single done held");
      wr(`LMPP_CTRL_OFS, 32'h0);
      repeat (2) @(posedge pclk);
      cmp(measurement_done, 1'b0, "done after disable");
      rd(`LMPP_RES_HIGH_OFS, d);
      cmp(d, 32'h0, "high byte disabled");
      $display("test single done");
   endtask : test_single
   // continuous: done lasts the hold time, then the next period ends
   task automatic test_cont;
      logic [31:0] d;
      int          n, h;
      wr(`LMPP_CTRL_OFS, {5'h0, 11'h4, 12'h0, 2'h1, 2'b01});
      n = 0;
      while (measurement_done !== 1'b1 && n < 1000) begin
         @(negedge pclk);
         n++;
      end
      h = 0;
      while (measurement_done === 1'b1 && h < 100) begin
         @(negedge pclk);
         h++;
      end
      cmp(h, DONE_HOLD, "hold");
      n = 0;
      while (measurement_done !== 1'b1 && n < 40) begin
         @(negedge pclk);
         n++;
      end
      cmp(measurement_done, 1'b1, "next period");
      wr(`LMPP_CTRL_OFS, 32'h0);
      rd(`LMPP_RES_LOW_OFS, d);
      cmp(d, 32'h0, "low byte disabled");
      rd(`LMPP_STAT_OFS, d);
      cmp(d, 32'h0, "status disabled");
      $display("test cont done");
   endtask : test_cont
   ////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the watchdog
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // watchdog: whole run needs about 18k cycles
   initial begin
      #1000000;
      errors++;
      complete_run();
   end
   // main sequence
   initial begin
      errors = 0; checks_done = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; ch_sample = '0; filt_sample = 16'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_shift();
      test_thresh();
      test_front();
      test_filter();
      test_single();
      test_cont();
      complete_run();
   end
endmodule : level_meter_post_processing_tb_top
